/* File: hw/bit_error_monitor.sv */
`timescale 1ns/1ns
module bit_error_monitor
  import spi_buffer_pkg::*;
(
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic link_clock,
  input  wire logic tx_pin_sense,
  input  wire logic tx_drive_bit,
  input  wire logic transfer_active,
  input  wire logic polarity,
  output logic      error_pulse
);

  logic              clock_meta;
  logic              clock_sync;
  logic              clock_last;
  logic              sense_meta;
  logic              sense_sync;
  logic              expected;
  logic              next_expected;
  logic              next_error_pulse;
  logic              transmit_edge;
  logic              receive_edge;
  monitor_state_type state;
  monitor_state_type next_state;

  ////////////////////////////////////////////////////////////////////////////////
  // Both pins share the same two-stage delay, so the sense stays aligned with the clock.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clock_meta <= 1'b0;
      clock_sync <= 1'b0;
      clock_last <= 1'b0;
      sense_meta <= 1'b0;
      sense_sync <= 1'b0;
    end else begin
      clock_meta <= link_clock;
      clock_sync <= clock_meta;
      clock_last <= clock_sync;
      sense_meta <= tx_pin_sense;
      sense_sync <= sense_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    transmit_edge    = (clock_sync != clock_last) && (clock_sync == polarity);
    receive_edge     = (clock_sync != clock_last) && (clock_sync != polarity);
    next_state       = state;
    next_expected    = expected;
    next_error_pulse = 1'b0;
    case (state)
      wait_transmit: begin
        if (transmit_edge && transfer_active) begin
          next_expected = tx_drive_bit;
          next_state    = wait_receive;
        end
      end
      wait_receive: begin
        if (!transfer_active) begin
          next_state = wait_transmit;
        end else if (receive_edge) begin
          next_error_pulse = (sense_sync != expected);
          next_state       = wait_transmit;
        end
      end
      default: next_state = wait_transmit;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state       <= wait_transmit;
      expected    <= 1'b0;
      error_pulse <= 1'b0;
    end else begin
      state       <= next_state;
      expected    <= next_expected;
      error_pulse <= next_error_pulse;
    end
  end

  mismatch_flagged_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (state == wait_receive && transfer_active && receive_edge && sense_sync != expected)
    |=> error_pulse)
    else $error("Transmit pin mismatch not flagged.");

endmodule : bit_error_monitor

/* File: hw/spi_buffer_pkg.sv */
package spi_buffer_pkg;

  localparam int ADDR_W = 8;

  // Register byte offsets.
  localparam logic [7:0] RECEIVE_BUFFER_OFF = 8'h00;
  localparam logic [7:0] SHIFT_DATA_OFF     = 8'h04;
  localparam logic [7:0] FLAG_REGISTER_OFF  = 8'h08;
  localparam logic [7:0] IRQ_MASK_OFF       = 8'h0C;
  localparam logic [7:0] CONTROL_OFF        = 8'h10;

  // Receive buffer field positions.
  localparam int RX_EMPTY_BIT   = 31;
  localparam int RX_OVERRUN_BIT = 30;
  localparam int TX_FULL_BIT    = 29;
  localparam int BIT_ERROR_BIT  = 28;
  localparam int RESERVED_HI    = 27;
  localparam int RESERVED_LO    = 18;
  localparam int SELECT_LO      = 16;

  // Flag register and mask register field positions.
  localparam int RX_IRQ_BIT      = 0;
  localparam int OVERRUN_IRQ_BIT = 1;
  localparam int BIT_ERROR_IRQ   = 2;
  localparam int FLAG_W          = 3;

  // Control register field positions.
  localparam int LENGTH_LO   = 0;
  localparam int POLARITY_BIT = 5;

  // Values after reset.
  localparam logic       RX_EMPTY_RESET  = 1'b1;
  localparam logic       OVERRUN_RESET   = 1'b0;
  localparam logic       TX_FULL_RESET   = 1'b0;
  localparam logic       BIT_ERROR_RESET = 1'b0;
  localparam logic [4:0] LENGTH_RESET    = 5'h10;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic {wait_transmit, wait_receive} monitor_state_type;

endpackage : spi_buffer_pkg

/* File: hw/spi_receive_buffer_status.sv */
`timescale 1ns/1ns
module spi_receive_buffer_status
  import spi_buffer_pkg::*;
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  output logic [1:0]             s_axi_bresp,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  input  wire logic              rx_copy,
  input  wire logic [15:0]       rx_word,
  input  wire logic [1:0]        rx_select,
  input  wire logic              tx_take,
  input  wire logic              transfer_active,
  input  wire logic              tx_drive_bit,
  input  wire logic              link_clock,
  input  wire logic              tx_pin_sense,
  output logic [15:0]            tx_word,
  output logic [1:0]             tx_select,
  output logic                   tx_buffer_full,
  output logic [4:0]             word_length,
  output logic                   clock_polarity,
  output logic                   irq
);

  function automatic logic [15:0] length_mask(input logic [4:0] len);
    length_mask = (len >= 5'h10) ? 16'hFFFF : 16'((17'h0_0001 << len) - 17'h0_0001);
  endfunction : length_mask

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                        input logic [3:0] strb);
    for (int i = 0; i < 4; i++) begin
      merge[8*i +: 8] = strb[i] ? data[8*i +: 8] : old[8*i +: 8];
    end
  endfunction : merge

  logic              aw_held;
  logic              w_held;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0]       w_data;
  logic [3:0]        w_strb;
  logic              rx_buffer_empty;
  logic              rx_overrun;
  logic              bit_error_status;
  logic [1:0]        last_select_number;
  logic [15:0]       rx_data;
  logic [FLAG_W-1:0] flag_register;
  logic [FLAG_W-1:0] irq_mask;
  logic              error_pulse;

  logic              next_aw_held;
  logic              next_w_held;
  logic [ADDR_W-1:0] next_aw_addr;
  logic [31:0]       next_w_data;
  logic [3:0]        next_w_strb;
  logic              next_awready;
  logic              next_wready;
  logic              next_bvalid;
  logic [1:0]        next_bresp;
  logic              next_arready;
  logic              next_rvalid;
  logic [31:0]       next_rdata;
  logic [1:0]        next_rresp;
  logic              next_rx_buffer_empty;
  logic              next_rx_overrun;
  logic              next_tx_buffer_full;
  logic              next_bit_error_status;
  logic [1:0]        next_last_select_number;
  logic [15:0]       next_rx_data;
  logic [FLAG_W-1:0] next_flag_register;
  logic [FLAG_W-1:0] next_irq_mask;
  logic [15:0]       next_tx_word;
  logic [1:0]        next_tx_select;
  logic [4:0]        next_word_length;
  logic              next_clock_polarity;
  logic              next_irq;

  logic              aw_have;
  logic              w_have;
  logic              write_commit;
  logic [ADDR_W-1:0] write_addr;
  logic [31:0]       write_data;
  logic [3:0]        write_strb;
  logic              shift_write;
  logic              read_fire;
  logic              buffer_read;
  logic              flag_read;
  logic              overrun_event;
  logic [31:0]       buffer_image;
  logic [31:0]       merged;

  ////////////////////////////////////////////////////////////////////////////////
  // Address and data are taken in either order; the response waits for both.
  always_comb begin
    aw_have      = aw_held || (s_axi_awvalid && s_axi_awready);
    w_have       = w_held || (s_axi_wvalid && s_axi_wready);
    write_commit = aw_have && w_have;
    write_addr   = aw_held ? aw_addr : s_axi_awaddr;
    write_data   = w_held ? w_data : s_axi_wdata;
    write_strb   = w_held ? w_strb : s_axi_wstrb;
    next_aw_held = aw_have && !write_commit;
    next_w_held  = w_have && !write_commit;
    next_aw_addr = aw_held ? aw_addr : s_axi_awaddr;
    next_w_data  = w_held ? w_data : s_axi_wdata;
    next_w_strb  = w_held ? w_strb : s_axi_wstrb;
    next_bvalid  = write_commit || (s_axi_bvalid && !s_axi_bready);
    next_bresp   = s_axi_bresp;
    if (write_commit) begin
      next_bresp = (write_addr == SHIFT_DATA_OFF || write_addr == IRQ_MASK_OFF ||
                    write_addr == CONTROL_OFF || write_addr == RECEIVE_BUFFER_OFF ||
                    write_addr == FLAG_REGISTER_OFF) ? RESP_OKAY : RESP_SLVERR;
    end
    next_awready = !next_aw_held && !next_bvalid;
    next_wready  = !next_w_held && !next_bvalid;
    shift_write  = write_commit && (write_addr == SHIFT_DATA_OFF);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read side effects happen on the address handshake, so the returned image is the old one.
  always_comb begin
    read_fire    = s_axi_arvalid && s_axi_arready;
    buffer_read  = read_fire && (s_axi_araddr == RECEIVE_BUFFER_OFF);
    flag_read    = read_fire && (s_axi_araddr == FLAG_REGISTER_OFF);
    buffer_image = 32'h0000_0000;
    buffer_image[RX_EMPTY_BIT]             = rx_buffer_empty;
    buffer_image[RX_OVERRUN_BIT]           = rx_overrun;
    buffer_image[TX_FULL_BIT]              = tx_buffer_full;
    buffer_image[BIT_ERROR_BIT]            = bit_error_status;
    buffer_image[SELECT_LO +: 2]           = last_select_number;
    buffer_image[15:0]                     = rx_data;
    next_rvalid  = read_fire || (s_axi_rvalid && !s_axi_rready);
    next_arready = !next_rvalid;
    next_rdata   = s_axi_rdata;
    next_rresp   = s_axi_rresp;
    if (read_fire) begin
      next_rresp = RESP_OKAY;
      case (s_axi_araddr)
        RECEIVE_BUFFER_OFF: next_rdata = buffer_image;
        SHIFT_DATA_OFF:     next_rdata = {14'h0000, tx_select, tx_word};
        FLAG_REGISTER_OFF:  next_rdata = {29'h0000_0000, flag_register};
        IRQ_MASK_OFF:       next_rdata = {29'h0000_0000, irq_mask};
        CONTROL_OFF:        next_rdata = {26'h000_0000, clock_polarity, word_length};
        default: begin
          next_rdata = 32'h0000_0000;
          next_rresp = RESP_SLVERR;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Hardware sets always win over software clears, so no event is lost to a racing read.
  always_comb begin
    overrun_event = rx_copy && !rx_buffer_empty;
    merged        = 32'h0000_0000;
    if (rx_copy) begin
      next_rx_buffer_empty = 1'b0;
    end else if (buffer_read) begin
      next_rx_buffer_empty = 1'b1;
    end else begin
      next_rx_buffer_empty = rx_buffer_empty;
    end
    if (overrun_event) begin
      next_rx_overrun = 1'b1;
    end else if (buffer_read) begin
      next_rx_overrun = 1'b0;
    end else begin
      next_rx_overrun = rx_overrun;
    end
    if (error_pulse) begin
      next_bit_error_status = 1'b1;
    end else if (buffer_read) begin
      next_bit_error_status = 1'b0;
    end else begin
      next_bit_error_status = bit_error_status;
    end
    next_last_select_number = rx_copy ? rx_select : last_select_number;
    next_rx_data = rx_copy ? (rx_word & length_mask(word_length)) : rx_data;
    next_flag_register = flag_register;
    if (flag_read) begin
      next_flag_register = '0;
    end
    if (buffer_read) begin
      next_flag_register[RX_IRQ_BIT]      = 1'b0;
      next_flag_register[OVERRUN_IRQ_BIT] = 1'b0;
    end
    next_flag_register[RX_IRQ_BIT]      = next_flag_register[RX_IRQ_BIT] || rx_copy;
    next_flag_register[OVERRUN_IRQ_BIT] = next_flag_register[OVERRUN_IRQ_BIT] || overrun_event;
    next_flag_register[BIT_ERROR_IRQ]   = next_flag_register[BIT_ERROR_IRQ] || error_pulse;
    next_tx_word        = tx_word;
    next_tx_select      = tx_select;
    next_irq_mask       = irq_mask;
    next_word_length    = word_length;
    next_clock_polarity = clock_polarity;
    if (shift_write) begin
      merged         = merge({14'h0000, tx_select, tx_word}, write_data, write_strb);
      next_tx_word   = merged[15:0];
      next_tx_select = merged[SELECT_LO +: 2];
    end
    if (write_commit && write_addr == IRQ_MASK_OFF && write_strb[0]) begin
      next_irq_mask = write_data[FLAG_W-1:0];
    end
    if (write_commit && write_addr == CONTROL_OFF && write_strb[0]) begin
      next_word_length    = write_data[LENGTH_LO +: 5];
      next_clock_polarity = write_data[POLARITY_BIT];
    end
    if (shift_write) begin
      next_tx_buffer_full = 1'b1;
    end else if (tx_take) begin
      next_tx_buffer_full = 1'b0;
    end else begin
      next_tx_buffer_full = tx_buffer_full;
    end
    next_irq = |(next_flag_register & next_irq_mask);
  end

  ////////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held            <= 1'b0;
      w_held             <= 1'b0;
      aw_addr            <= '0;
      w_data             <= 32'h0000_0000;
      w_strb             <= 4'h0;
      s_axi_awready      <= 1'b1;
      s_axi_wready       <= 1'b1;
      s_axi_bvalid       <= 1'b0;
      s_axi_bresp        <= RESP_OKAY;
      s_axi_arready      <= 1'b1;
      s_axi_rvalid       <= 1'b0;
      s_axi_rdata        <= 32'h0000_0000;
      s_axi_rresp        <= RESP_OKAY;
      rx_buffer_empty    <= RX_EMPTY_RESET;
      rx_overrun         <= OVERRUN_RESET;
      tx_buffer_full     <= TX_FULL_RESET;
      bit_error_status   <= BIT_ERROR_RESET;
      last_select_number <= 2'h0;
      rx_data            <= 16'h0000;
      flag_register      <= '0;
      irq_mask           <= '0;
      tx_word            <= 16'h0000;
      tx_select          <= 2'h0;
      word_length        <= LENGTH_RESET;
      clock_polarity     <= 1'b0;
      irq                <= 1'b0;
    end else begin
      aw_held            <= next_aw_held;
      w_held             <= next_w_held;
      aw_addr            <= next_aw_addr;
      w_data             <= next_w_data;
      w_strb             <= next_w_strb;
      s_axi_awready      <= next_awready;
      s_axi_wready       <= next_wready;
      s_axi_bvalid       <= next_bvalid;
      s_axi_bresp        <= next_bresp;
      s_axi_arready      <= next_arready;
      s_axi_rvalid       <= next_rvalid;
      s_axi_rdata        <= next_rdata;
      s_axi_rresp        <= next_rresp;
      rx_buffer_empty    <= next_rx_buffer_empty;
      rx_overrun         <= next_rx_overrun;
      tx_buffer_full     <= next_tx_buffer_full;
      bit_error_status   <= next_bit_error_status;
      last_select_number <= next_last_select_number;
      rx_data            <= next_rx_data;
      flag_register      <= next_flag_register;
      irq_mask           <= next_irq_mask;
      tx_word            <= next_tx_word;
      tx_select          <= next_tx_select;
      word_length        <= next_word_length;
      clock_polarity     <= next_clock_polarity;
      irq                <= next_irq;
    end
  end

  bit_error_monitor monitor (
    .aclk            (aclk),
    .aresetn         (aresetn),
    .link_clock      (link_clock),
    .tx_pin_sense    (tx_pin_sense),
    .tx_drive_bit    (tx_drive_bit),
    .transfer_active (transfer_active),
    .polarity        (clock_polarity),
    .error_pulse     (error_pulse)
  );

  ////////////////////////////////////////////////////////////////////////////////
  flags_cleared_a: assert property (@(posedge aclk) disable iff (!aresetn)
    buffer_read && !rx_copy |=> !flag_register[RX_IRQ_BIT] && !flag_register[OVERRUN_IRQ_BIT])
    else $error("Buffer read left interrupt flags set.");
  empty_on_read_a: assert property (@(posedge aclk) disable iff (!aresetn)
    buffer_read && !rx_copy |=> rx_buffer_empty)
    else $error("Receive-empty not set by read.");
  empty_on_copy_a: assert property (@(posedge aclk) disable iff (!aresetn)
    rx_copy |=> !rx_buffer_empty)
    else $error("Receive-empty not cleared by copy.");
  overrun_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
    rx_copy && !rx_buffer_empty |=> rx_overrun ##0 flag_register[OVERRUN_IRQ_BIT])
    else $error("Overrun not flagged.");
  overrun_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    rx_overrun && !buffer_read |=> rx_overrun)
    else $error("Overrun dropped without a read.");
  overrun_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
    buffer_read && !overrun_event |=> !rx_overrun)
    else $error("Overrun not cleared by read.");
  tx_full_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
    shift_write |=> tx_buffer_full)
    else $error("Transmit-full not set by write.");
  tx_full_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
    tx_take && !shift_write |=> !tx_buffer_full)
    else $error("Transmit-full not cleared by take.");
  buffer_image_a: assert property (@(posedge aclk) disable iff (!aresetn)
    buffer_read |=> s_axi_rvalid && s_axi_rdata[RESERVED_HI:RESERVED_LO] == 10'h000
      && s_axi_rdata[BIT_ERROR_BIT] == $past(bit_error_status))
    else $error("Buffer read image wrong.");
  error_latched_a: assert property (@(posedge aclk) disable iff (!aresetn)
    error_pulse |=> bit_error_status && flag_register[BIT_ERROR_IRQ])
    else $error("Bit error not latched.");
  select_copied_a: assert property (@(posedge aclk) disable iff (!aresetn)
    rx_copy |=> last_select_number == $past(rx_select))
    else $error("Last select not copied.");
  data_justified_a: assert property (@(posedge aclk) disable iff (!aresetn)
    rx_copy |=> rx_data == ($past(rx_word) & length_mask($past(word_length))))
    else $error("Received data not right-justified.");
  copy_wins_a: assert property (@(posedge aclk) disable iff (!aresetn)
    rx_copy && buffer_read && !rx_buffer_empty |=> !rx_buffer_empty && rx_overrun)
    else $error("Read won over copy.");

endmodule : spi_receive_buffer_status

/* File: test/axi_host_model.sv */
`timescale 1ns/1ns
module axi_host_model
  import spi_buffer_pkg::*;
(
  input  wire logic         aclk,
  output logic              s_axi_awvalid,
  input  wire logic         s_axi_awready,
  output logic [ADDR_W-1:0] s_axi_awaddr,
  output logic              s_axi_wvalid,
  input  wire logic         s_axi_wready,
  output logic [31:0]       s_axi_wdata,
  output logic [3:0]        s_axi_wstrb,
  input  wire logic         s_axi_bvalid,
  output logic              s_axi_bready,
  input  wire logic [1:0]   s_axi_bresp,
  output logic              s_axi_arvalid,
  input  wire logic         s_axi_arready,
  output logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic         s_axi_rvalid,
  output logic              s_axi_rready,
  input  wire logic [31:0]  s_axi_rdata,
  input  wire logic [1:0]   s_axi_rresp
);
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
  end

  // The host waits on every handshake without a limit; only the bench timeout can end a wait.
  task automatic write_reg(input logic [ADDR_W-1:0] a, input logic [31:0] d,
                           output logic [1:0] r);
    logic aw_done;
    logic w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge aclk);
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr <= a;
    s_axi_wvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_bready <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge aclk);
      aw_done = aw_done | s_axi_awready;
      w_done = w_done | s_axi_wready;
      s_axi_awvalid <= !aw_done;
      s_axi_wvalid <= !w_done;
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : write_reg

  task automatic read_reg(input logic [ADDR_W-1:0] a, output logic [31:0] d,
                          output logic [1:0] r);
    @(posedge aclk);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr <= a;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : read_reg
endmodule : axi_host_model

/* File: test/testbench.sv */
`timescale 1ns/1ns
module testbench
  import spi_buffer_pkg::*;
;
  logic              aclk, aresetn, rx_copy, tx_take, transfer_active, tx_drive_bit;
  logic              link_clock, tx_pin_sense, tx_buffer_full, clock_polarity, irq;
  logic              s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic              s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic              s_axi_rvalid, s_axi_rready;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0]       s_axi_wdata, s_axi_rdata;
  logic [3:0]        s_axi_wstrb;
  logic [1:0]        s_axi_bresp, s_axi_rresp, rx_select, tx_select;
  logic [15:0]       rx_word, tx_word;
  logic [4:0]        word_length;
  int                fails = 0;
  int                num_checks = 0;
  int                cycles = 0;

  spi_receive_buffer_status u_spi_receive_buffer_status (
    .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid,
    .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
    .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
    .s_axi_rdata, .s_axi_rresp, .rx_copy, .rx_word, .rx_select, .tx_take, .transfer_active,
    .tx_drive_bit, .link_clock, .tx_pin_sense, .tx_word, .tx_select, .tx_buffer_full,
    .word_length, .clock_polarity, .irq);
  axi_host_model u_axi_host_model (
    .aclk, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
    .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
    .s_axi_rresp);

  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      fails++;
      finish_test();
    end
  end
////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      fails++;
    end
  endtask : check
  task automatic read_expect(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0]  r;
    u_axi_host_model.read_reg(a, d, r);
    check("read data", d, exp);
    check("read resp", r, (a > CONTROL_OFF) ? RESP_SLVERR : RESP_OKAY);
  endtask : read_expect
  task automatic write_okay(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    logic [1:0] r;
    u_axi_host_model.write_reg(a, d, r);
    check("write resp", r, RESP_OKAY);
  endtask : write_okay
  task automatic copy_word(input logic [15:0] w, input logic [1:0] s);
    @(posedge aclk);
    rx_copy <= 1'b1;
    rx_word <= w;
    rx_select <= s;
    @(posedge aclk);
    rx_copy <= 1'b0;
    rx_word <= ~w;
  endtask : copy_word
  // The link clock runs only inside a frame, toggling every 400 ns, 33 ns after a rising edge of aclk.
  task automatic frame(input logic bad);
    @(posedge aclk);
    transfer_active <= 1'b1;
    tx_pin_sense <= ~bad;
    #33;
    repeat (8) #400 link_clock = ~link_clock;
    repeat (8) @(posedge aclk);
    transfer_active <= 1'b0;
    tx_pin_sense <= 1'b1;
  endtask : frame
////////////////////////////////////////////////////////////////////////////////
  task automatic receive_and_irq;
    write_okay(IRQ_MASK_OFF, 32'h0000_0001);
    copy_word(16'ha5c3, 2'h2);
    repeat (2) @(posedge aclk);
    check("irq raised", irq, 1'b1);
    read_expect(RECEIVE_BUFFER_OFF, 32'h0002_a5c3);
    @(posedge aclk);
    check("irq cleared", irq, 1'b0);
    read_expect(RECEIVE_BUFFER_OFF, 32'h8002_a5c3);
  endtask : receive_and_irq
  task automatic overrun;
    copy_word(16'h1234, 2'h1);
    copy_word(16'h5678, 2'h3);
    read_expect(RECEIVE_BUFFER_OFF, 32'h4003_5678);
    read_expect(FLAG_REGISTER_OFF, 32'h0000_0000);
    read_expect(RECEIVE_BUFFER_OFF, 32'h8003_5678);
  endtask : overrun
  task automatic short_word;
    write_okay(CONTROL_OFF, 32'h0000_0008);
    check("word length", word_length, 5'h08);
    copy_word(16'hffab, 2'h0);
    read_expect(RECEIVE_BUFFER_OFF, 32'h0000_00ab);
  endtask : short_word
  task automatic transmit;
    write_okay(SHIFT_DATA_OFF, 32'h0001_beef);
    check("tx full set", tx_buffer_full, 1'b1);
    check("tx word", {tx_select, tx_word}, 18'h1_beef);
    read_expect(RECEIVE_BUFFER_OFF, 32'ha000_00ab);
    @(posedge aclk);
    tx_take <= 1'b1;
    @(posedge aclk);
    tx_take <= 1'b0;
    @(posedge aclk);
    check("tx full clear", tx_buffer_full, 1'b0);
    write_okay(RECEIVE_BUFFER_OFF, 32'hffff_ffff);
    read_expect(8'h20, 32'h0000_0000);
    read_expect(RECEIVE_BUFFER_OFF, 32'h8000_00ab);
  endtask : transmit
  task automatic bit_error;
    frame(1'b0);
    read_expect(RECEIVE_BUFFER_OFF, 32'h8000_00ab);
    frame(1'b1);
    read_expect(FLAG_REGISTER_OFF, 32'h0000_0004);
    read_expect(RECEIVE_BUFFER_OFF, 32'h9000_00ab);
    read_expect(RECEIVE_BUFFER_OFF, 32'h8000_00ab);
  endtask : bit_error
  task automatic copy_during_read;
    copy_word(16'h0311, 2'h1);
    fork
      copy_word(16'h0322, 2'h2);
      read_expect(RECEIVE_BUFFER_OFF, 32'h0001_0011);
    join
    read_expect(RECEIVE_BUFFER_OFF, 32'h4002_0022);
    read_expect(RECEIVE_BUFFER_OFF, 32'h8002_0022);
  endtask : copy_during_read
  // The link clock is parked at the new idle level before the polarity changes.
  task automatic polarity_high;
    link_clock <= 1'b1;
    write_okay(CONTROL_OFF, 32'h0000_0030);
    check("clock polarity", clock_polarity, 1'b1);
    frame(1'b0);
    read_expect(FLAG_REGISTER_OFF, 32'h0000_0000);
    frame(1'b1);
    read_expect(FLAG_REGISTER_OFF, 32'h0000_0004);
    read_expect(RECEIVE_BUFFER_OFF, 32'h9002_0022);
  endtask : polarity_high
  task automatic finish_test;
    if (fails == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : finish_test
////////////////////////////////////////////////////////////////////////////////
  initial begin
    {aresetn, rx_copy, tx_take, transfer_active, link_clock} = 5'h0;
    {tx_drive_bit, tx_pin_sense, rx_word, rx_select} = 20'hc_0000;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    read_expect(RECEIVE_BUFFER_OFF, 32'h8000_0000);
    receive_and_irq();
    overrun();
    short_word();
    transmit();
    bit_error();
    copy_during_read();
    polarity_high();
    finish_test();
  end
endmodule : testbench
